// *** core/eirl_top.v ***
// event interrupt request logic: per-chip, per-link/lane and single per-link register blocks
// assumes a synchronous register port and an external pull-up on the shared interrupt line
`timescale 1ns/1ns
`include "eirl_defs.vh"
module eirl_top (
  input wire clk,                            // 20 MHz device digital clock
  input wire reset,                          // async reset, active high
  input wire [`EIRL_ADDR_W-1:0] reg_addr,    // register address
  input wire [`EIRL_DATA_W-1:0] reg_wdata,   // register write data
  input wire reg_wr,                         // write strobe, one cycle
  input wire reg_rd,                         // read strobe, one cycle
  output wire [`EIRL_DATA_W-1:0] reg_rdata,  // read data, valid cycle after reg_rd
  input wire [`EIRL_CHIP_EVENTS-1:0] chip_event, // per-chip events, bit 8*k+b at 0x023+k bit b
  input wire [`EIRL_GRP_EVENTS-1:0] link_event,  // link/lane events, bit 8*g+b at 0x46d+g bit b
  input wire single_event,                   // per-link event at link_single_event_ctrl bit 4
  input wire irq_n_in,                       // level of the shared interrupt line
  output wire irq_n_out,                     // interrupt pin output value, always low
  output wire irq_n_oe                       // high while pulling the line low
);
  reg [31:0] chip_en_ff;
  reg [7:0] link_en_ff;
  reg single_en_ff;
  reg [`EIRL_DATA_W-1:0] rdata_ff;
  reg [`EIRL_DATA_W-1:0] nxt_rdata;
  reg irq_oe_ff;
  reg irq_out_ff;

  wire [31:0] chip_flag;
  wire [31:0] chip_level;
  wire [31:0] chip_clr;
  wire [`EIRL_GRP_EVENTS-1:0] grp_flag;
  wire [`EIRL_GRP_EVENTS-1:0] grp_en;
  wire [`EIRL_GRP_EVENTS-1:0] grp_clr;
  wire [7:0] grp_stat;
  wire single_flag;
  wire single_clr;
  wire any_flag;

  // one write port; clears exist only in the write cycle
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_chip
      assign chip_clr[8*k +: 8] =
        (reg_wr && reg_addr == `EIRL_CHIP_FLAGS_0 + k) ? reg_wdata : 8'h00;
    end
    for (k = 0; k < `EIRL_GROUPS; k = k + 1) begin : g_grp
      assign grp_clr[8*k +: 8] =
        (reg_wr && reg_addr == `EIRL_LANE_CLR_0 + k) ? reg_wdata : 8'h00;
      // one link enable bit gates a whole clear group
      assign grp_en[8*k +: 8] = {8{link_en_ff[k]}};
      assign grp_stat[k] = link_en_ff[k] & (|grp_flag[8*k +: 8]);
    end
  endgenerate
  assign grp_stat[7] = 1'b0;
  assign single_clr = reg_wr && reg_addr == `EIRL_LINK_SINGLE && reg_wdata[`EIRL_SINGLE_FLAG_BIT];

  // prbs fails on chip_event[11:8], blanking done on [21] and [29]
  eirl_flag_bank #(.N(32)) u_chip (
    .clk(clk),
    .reset(reset),
    .event_in(chip_event),
    .enable(chip_en_ff),
    .clear(chip_clr),
    .flag(chip_flag),
    .level(chip_level)
  );

  eirl_flag_bank #(.N(`EIRL_GRP_EVENTS)) u_grp (
    .clk(clk),
    .reset(reset),
    .event_in(link_event),
    .enable(grp_en),
    .clear(grp_clr),
    .flag(grp_flag),
    .level()
  );

  eirl_flag_bank #(.N(1)) u_single (
    .clk(clk),
    .reset(reset),
    .event_in(single_event),
    .enable(single_en_ff),
    .clear(single_clr),
    .flag(single_flag),
    .level()
  );

  assign any_flag = (|chip_flag) | (|grp_flag) | single_flag;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      chip_en_ff <= `EIRL_CHIP_EN_RST;
      link_en_ff <= `EIRL_LINK_EN_RST;
      single_en_ff <= `EIRL_SINGLE_EN_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `EIRL_CHIP_EN_0: chip_en_ff[7:0] <= reg_wdata;
        `EIRL_CHIP_EN_1: chip_en_ff[15:8] <= reg_wdata;
        `EIRL_CHIP_EN_2: chip_en_ff[23:16] <= reg_wdata;
        `EIRL_CHIP_EN_3: chip_en_ff[31:24] <= reg_wdata;
        `EIRL_LINK_EN_STAT: link_en_ff <= reg_wdata;
        `EIRL_LINK_SINGLE: single_en_ff <= reg_wdata[`EIRL_SINGLE_EN_BIT];
        default: single_en_ff <= single_en_ff;
      endcase
    end
  end

  // chip status shows live level when disabled so the host can poll the source
  always @* begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      case (reg_addr)
        `EIRL_CHIP_EN_0: nxt_rdata = chip_en_ff[7:0];
        `EIRL_CHIP_EN_1: nxt_rdata = chip_en_ff[15:8];
        `EIRL_CHIP_EN_2: nxt_rdata = chip_en_ff[23:16];
        `EIRL_CHIP_EN_3: nxt_rdata = chip_en_ff[31:24];
        `EIRL_CHIP_FLAGS_0: nxt_rdata = (chip_en_ff[7:0] & chip_flag[7:0]) |
                                        (~chip_en_ff[7:0] & chip_level[7:0]);
        `EIRL_CHIP_FLAGS_1: nxt_rdata = (chip_en_ff[15:8] & chip_flag[15:8]) |
                                        (~chip_en_ff[15:8] & chip_level[15:8]);
        `EIRL_CHIP_FLAGS_2: nxt_rdata = (chip_en_ff[23:16] & chip_flag[23:16]) |
                                        (~chip_en_ff[23:16] & chip_level[23:16]);
        `EIRL_CHIP_FLAGS_3: nxt_rdata = (chip_en_ff[31:24] & chip_flag[31:24]) |
                                        (~chip_en_ff[31:24] & chip_level[31:24]);
        `EIRL_LINK_EN_STAT: nxt_rdata = grp_stat;
        `EIRL_LINK_SINGLE: nxt_rdata = {3'b000, single_en_ff & single_flag, single_en_ff, 3'b000};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= 8'h00;
      irq_oe_ff <= 1'b0;
      irq_out_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      irq_oe_ff <= any_flag;
      irq_out_ff <= 1'b0; // only ever pulls low
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq_n_out = irq_out_ff;
  assign irq_n_oe = irq_oe_ff;
endmodule // eirl_top

// *** core/eirl_defs.vh ***
// register map, field positions and reset values of the event interrupt request logic
// assumes an 8-bit register port with 12-bit addresses
`ifndef EIRL_DEFS_VH
`define EIRL_DEFS_VH

`define EIRL_ADDR_W 12
`define EIRL_DATA_W 8

`define EIRL_CHIP_EN_0 12'h01f
`define EIRL_CHIP_EN_1 12'h020
`define EIRL_CHIP_EN_2 12'h021
`define EIRL_CHIP_EN_3 12'h022
`define EIRL_CHIP_FLAGS_0 12'h023
`define EIRL_CHIP_FLAGS_1 12'h024
`define EIRL_CHIP_FLAGS_2 12'h025
`define EIRL_CHIP_FLAGS_3 12'h026
`define EIRL_LANE_CLR_0 12'h46d
`define EIRL_LANE_CLR_1 12'h46e
`define EIRL_LANE_CLR_2 12'h46f
`define EIRL_LINK_CLR_0 12'h470
`define EIRL_LINK_CLR_1 12'h471
`define EIRL_LINK_CLR_2 12'h472
`define EIRL_LINK_CLR_3 12'h473
`define EIRL_LINK_EN_STAT 12'h47a
`define EIRL_LINK_SINGLE 12'h47b

`define EIRL_SINGLE_EN_BIT 3
`define EIRL_SINGLE_FLAG_BIT 4

`define EIRL_CHIP_EN_RST 32'h00000000
`define EIRL_LINK_EN_RST 8'h00
`define EIRL_SINGLE_EN_RST 1'b1

`define EIRL_CHIP_EVENTS 32
`define EIRL_GRP_EVENTS 56
`define EIRL_GROUPS 7

`endif

// *** core/eirl_flag_bank.v ***
// bank of latched event flags with rising-edge detection
// assumes events, enables and clears are synchronous to clk
`timescale 1ns/1ns
module eirl_flag_bank #(
  parameter N = 8
) (
  input wire clk,              // device digital clock
  input wire reset,            // async reset, active high
  input wire [N-1:0] event_in, // live event levels
  input wire [N-1:0] enable,   // per-event interrupt enable
  input wire [N-1:0] clear,    // one-cycle flag-clear pulses
  output wire [N-1:0] flag,    // latched flags
  output wire [N-1:0] level    // registered live event level
);
  reg [N-1:0] ev_ff;
  reg [N-1:0] flag_ff;
  wire [N-1:0] nxt_flag;
  wire [N-1:0] rise;

  assign rise = event_in & ~ev_ff;
  assign flag = flag_ff;
  assign level = ev_ff;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_cell
      // one driver per bit; a disable beats everything, a rising edge beats a clear
      assign nxt_flag[i] = !enable[i] ? 1'b0 :
                           rise[i] ? 1'b1 :
                           clear[i] ? 1'b0 :
                           flag_ff[i];
    end
  endgenerate

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ev_ff <= {N{1'b0}};
      flag_ff <= {N{1'b0}}; // device reset clears flags
    end else begin
      ev_ff <= event_in;
      flag_ff <= nxt_flag;
    end
  end
endmodule // eirl_flag_bank

// *** testbench/eirl_top_assertions.sv ***
// port checker for eirl_top
// assumes binding to eirl_top; one clock, async active-high reset
`timescale 1ns/1ns
module eirl_top_chk (
  input wire clk, // clock
  input wire reset, // reset
  input wire [11:0] reg_addr, // address
  input wire [7:0] reg_wdata, // write data
  input wire reg_wr, // write
  input wire reg_rd, // read
  input wire [7:0] reg_rdata, // read data
  input wire [31:0] chip_event, // chip events
  input wire [55:0] link_event, // link events
  input wire single_event, // single event
  input wire irq_n_in, // line
  input wire irq_n_out, // pin value
  input wire irq_n_oe // pin enable
);
  wire [88:0] ev = {single_event, link_event, chip_event};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_PIN_LOW: assert property (irq_n_out == 1'b0) else $error("pin value high");
  AST_RISE: assert property ($rose(irq_n_oe) |-> |($past(ev, 2) & ~$past(ev, 3))) else $error("irq no edge");
  AST_FALL: assert property ($fell(irq_n_oe) |-> $past(reg_wr, 2) || $past(reg_wr, 3)) else $error("irq drop");
  AST_HOLD: assert property (!$past(reg_rd) |-> $stable(reg_rdata)) else $error("rdata moved");
  AST_CLR_RD: assert property (reg_rd && reg_addr >= 12'h46d && reg_addr <= 12'h473 |=> reg_rdata == 8'h00)
    else $error("clear reg read");
  AST_B7: assert property (reg_rd && reg_addr == 12'h47a |=> !reg_rdata[7]) else $error("47a bit7");
  AST_47B: assert property (reg_rd && reg_addr == 12'h47b |=> (reg_rdata & 8'he7) == 8'h00)
    else $error("47b spare bits");
  AST_47B_EN: assert property (reg_rd && reg_addr == 12'h47b |=> !reg_rdata[4] || reg_rdata[3])
    else $error("47b flag w/o enable");
endmodule // eirl_top_chk

// *** testbench/eirl_wired_line.sv ***
// wired-or interrupt line: host pull-up plus one more open-drain device
// assumes active-high pull enables
`timescale 1ns/1ns
module eirl_wired_line (
  input wire logic dut_oe, // our pin pulls low
  input wire logic other_oe, // other device pulls low
  output wire logic line_n // line level
);
  assign line_n = (dut_oe || other_oe) ? 1'b0 : 1'b1;
endmodule // eirl_wired_line

// *** testbench/tb_eirl_top.sv ***
// self-checking bench for eirl_top
// assumes eirl_wired_line as the host side of the interrupt line
`timescale 1ns/1ns
module tb_eirl_top;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, single_event = 0, other_oe = 0;
  logic [11:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0;
  logic [31:0] chip_event = 0;
  logic [55:0] link_event = 0;
  wire [7:0] reg_rdata;
  wire irq_n_in, irq_n_out, irq_n_oe;
  int n_fail = 0, comparisons = 0, cyc = 0;
  always #25 clk = ~clk;
  eirl_top u_dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chip_event,
    .link_event, .single_event, .irq_n_in, .irq_n_out, .irq_n_oe);
  eirl_wired_line u_line (.dut_oe(irq_n_oe), .other_oe, .line_n(irq_n_in));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask
  // one-cycle event pulse, then time for flag and pin to follow
  task pulse(input int i);
    @(posedge clk);
    {single_event, link_event, chip_event} <= 89'd1 << i;
    @(posedge clk);
    {single_event, link_event, chip_event} <= '0;
    repeat (3) @(posedge clk);
  endtask
  task print_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    reset <= 0;
    rd(12'h01f, 8'h00);
    rd(12'h47b, 8'h08);
    rd(12'h46d, 8'h00);
    $display("done reset values");
    @(posedge clk) chip_event[11:8] <= 4'ha;
    rd(12'h024, 8'h0a);
    @(posedge clk) chip_event <= 0;
    #1 chk({7'h0, irq_n_oe}, 8'h00);
    wr(12'h020, 8'h0f);
    rd(12'h020, 8'h0f);
    pulse(9);
    chk({5'h0, irq_n_out, irq_n_oe, irq_n_in}, 8'h02);
    rd(12'h024, 8'h02);
    // host service sequence: disable, clear, re-enable
    wr(12'h020, 8'h00);
    rd(12'h024, 8'h00);
    wr(12'h024, 8'h02);
    wr(12'h020, 8'h0f);
    pulse(8);
    wr(12'h024, 8'h01);
    rd(12'h024, 8'h00);
    #1 chk({6'h0, irq_n_oe, irq_n_in}, 8'h01);
    // clear write and a fresh rising edge taken at the same edge
    @(posedge clk) begin
      reg_addr <= 12'h024;
      reg_wdata <= 8'h01;
      reg_wr <= 1;
      chip_event[8] <= 1;
    end
    @(posedge clk) begin
      reg_wr <= 0;
      chip_event[8] <= 0;
    end
    rd(12'h024, 8'h01);
    wr(12'h024, 8'h01);
    rd(12'h024, 8'h00);
    $display("done chip block");
    wr(12'h021, 8'h20);
    wr(12'h022, 8'h20);
    @(posedge clk) chip_event[29] <= 1;
    rd(12'h026, 8'h20);
    wr(12'h026, 8'h20);
    rd(12'h026, 8'h00);
    pulse(21);
    rd(12'h025, 8'h20);
    // the link_single_event_ctrl enable resets to 1, so its flag shows whether reset cleared it
    pulse(88);
    rd(12'h47b, 8'h18);
    @(posedge clk) reset <= 1;
    @(posedge clk) reset <= 0;
    rd(12'h025, 8'h00);
    rd(12'h47b, 8'h08);
    #1 chk({6'h0, irq_n_oe, irq_n_in}, 8'h01);
    $display("done blanking and reset");
    @(posedge clk) link_event[0] <= 1;
    rd(12'h47a, 8'h00);
    @(posedge clk) link_event[0] <= 0;
    rd(12'h47a, 8'h00);
    wr(12'h47a, 8'h7f);
    for (int g = 0; g < 7; g++) begin
      pulse(32 + 9 * g);
      rd(12'h47a, 8'h01 << g);
      wr(12'h46d + g, 8'h01 << g);
      rd(12'h47a, 8'h00);
    end
    pulse(88);
    rd(12'h47b, 8'h18);
    wr(12'h47b, 8'h18);
    rd(12'h47b, 8'h08);
    @(posedge clk) other_oe <= 1;
    #1 chk({6'h0, irq_n_oe, irq_n_in}, 8'h00);
    $display("done link blocks and line");
    print_verdict();
  end
endmodule // tb_eirl_top
bind eirl_top eirl_top_chk u_chk (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .chip_event, .link_event, .single_event, .irq_n_in, .irq_n_out, .irq_n_oe);
